// [logic/rcb_top.sv]
/*
  Chip reset and boot-configuration logic: reset qualification and stretching,
  clock-mode decode, crystal pin control, clock output, flash programming entry.
  Assumes the boot pins are asynchronous to CLK and software uses APB.
*/
//
// Operation
// RULE1 - A reset pin held low for at least 8 clock cycles resets CPU and peripherals.
// RULE2 - The reset output stays low for 1024 cycles after the reset source releases.
// RULE3 - The two clock-mode pins select the boot clock configuration.
// RULE4 - Modes 10 and 11 run the PLL, modes 00 and 01 disable it.
// RULE5 - Modes 01 and 11 use the crystal and ignore the crystal pin level.
// RULE6 - Modes 00 and 10 sample the crystal pin: 0 picks external, 1 on-chip oscillator.
// RULE7 - The oscillator input pin is used except when the on-chip oscillator is chosen.
// RULE8 - The crystal pin is driven as oscillator output unless it is being sampled.
// RULE9 - The system clock is presented on the clock output pin; here the pin carries CLK divided by two, while enabled.
// RULE10 - Boot config low with test low at reset exit enters flash programming mode.
// RULE11 - In flash programming mode the serial flash port gets the on-chip flash.
// RULE12 - The board keeps the test pin low in normal operation.
// RULE13 - The reset pin is synchronised and the output stays low while any source is on.
`default_nettype none

module rcb_top
  import rcb_pkg::*;
#(
  parameter int unsigned QUAL_CYCLES    = RESET_QUAL_CYCLES,
  parameter int unsigned STRETCH_CYCLES = RESET_STRETCH_CYCLES
) (
  // Clock and power-on reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // Board pins
  input  wire logic        RESET_IN_N,
  input  wire logic [1:0]  CLOCK_MODE_SELECT,
  input  wire logic        BOOT_CONFIG_N,
  input  wire logic        TEST_PIN,
  input  wire logic        OSC_CLOCK_INPUT,
  input  wire logic        CRYSTAL_PIN_IN,
  output var  logic        CRYSTAL_PIN_OUT,
  output var  logic        CRYSTAL_PIN_OE,
  output var  logic        RESET_OUT_N,
  output var  logic        SYSTEM_CLOCK_OUTPUT,
  // Chip-internal controls
  output var  logic        CHIP_RESET,
  output var  logic        PLL_ENABLE,
  output var  logic [1:0]  CLOCK_SOURCE,
  output var  logic        OSC_INPUT_ENABLE,
  output var  logic        FLASH_PROG_MODE,
  output var  logic        FLASH_PORT_ACCESS
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int unsigned CW = $clog2(STRETCH_CYCLES);

  logic [4:0]   pin_sync1;
  logic [4:0]   pin_sync2;
  logic [1:0]   mode_s;
  logic         crystal_pin_s;
  logic         boot_n_s;
  logic         test_s;
  logic         osc_s;
  logic         pin_reset;
  logic         sw_reset;
  logic         source;
  rcb_phase_t   phase;
  rcb_phase_t   next_phase;
  logic [CW-1:0] stretch_count;
  logic [1:0]   mode_latched;
  logic         crystal_pin_latched;
  rcb_clk_src_t clk_src;
  logic         flash_mode;
  logic         cause_pin;
  logic         cause_sw;
  logic         system_clock_output_en;
  logic         setup;
  logic         wr_access;
  logic         leaving_hold;
  logic [1:0]   sync_ready;

  function automatic rcb_clk_src_t decode_src(input logic [1:0] mode, input logic crystal_pin);
    if (mode[0])
      return SRC_CRYSTAL;
    return crystal_pin ? SRC_ONCHIP : SRC_EXT_OSC;
  endfunction : decode_src

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_sync1 <= '0;
      pin_sync2 <= '0;
    end else begin
      pin_sync1 <= {OSC_CLOCK_INPUT, TEST_PIN, BOOT_CONFIG_N, CRYSTAL_PIN_IN,
                    CLOCK_MODE_SELECT[0]};
      pin_sync2 <= pin_sync1;
    end
  end

  logic mode_sync1;
  logic mode_sync2;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_sync1 <= 1'b0;
      mode_sync2 <= 1'b0;
    end else begin
      mode_sync1 <= CLOCK_MODE_SELECT[1];
      mode_sync2 <= mode_sync1;
    end
  end

  // Keep the chip in reset until the synchronisers carry real pin levels,
  // so the straps are never latched from flop reset values
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_ready <= '0;
    end else begin
      sync_ready <= {sync_ready[0], 1'b1};
    end
  end

  assign mode_s   = {mode_sync2, pin_sync2[0]};
  assign crystal_pin_s   = pin_sync2[1];
  assign boot_n_s = pin_sync2[2];
  assign test_s   = pin_sync2[3];
  assign osc_s    = pin_sync2[4];

  // ****************************************
  // Reset sources and sequencing
  // ****************************************
  rcb_reset_filter #(
    .QUAL      (QUAL_CYCLES)
  ) u_filter (
    .clk       (CLK),
    .rst       (RST),
    .pin_n     (RESET_IN_N),
    .qualified (pin_reset)
  );

  assign source       = pin_reset | sw_reset | !sync_ready[1]; // RULE13
  assign leaving_hold = (phase == PH_HOLD) && !source;

  always_comb begin
    next_phase = phase;
    unique case (phase)
      PH_HOLD: begin
        if (!source)
          next_phase = PH_STRETCH;
      end
      PH_STRETCH: begin
        if (source)
          next_phase = PH_HOLD; // RULE13
        else if (stretch_count == CW'(STRETCH_CYCLES - 1))
          next_phase = PH_RUN; // RULE2
      end
      PH_RUN: begin
        if (source)
          next_phase = PH_HOLD; // RULE1
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase <= PH_HOLD;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stretch_count <= '0;
    end else if (phase == PH_STRETCH) begin
      stretch_count <= stretch_count + 1'b1; // RULE2
    end else begin
      stretch_count <= '0;
    end
  end

  // Outputs follow the phase register, so each comes from a flop
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CHIP_RESET  <= 1'b1;
      RESET_OUT_N <= 1'b0;
    end else begin
      CHIP_RESET  <= (next_phase == PH_HOLD); // RULE1
      RESET_OUT_N <= (next_phase == PH_RUN); // RULE2
    end
  end

  // ****************************************
  // Boot configuration capture
  // ****************************************
  // Sampled once, as the last reset source releases; later pin changes are ignored
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_latched <= '0;
      crystal_pin_latched <= 1'b0;
      clk_src      <= SRC_EXT_OSC;
    end else if (leaving_hold) begin
      mode_latched <= mode_s; // RULE3
      crystal_pin_latched <= crystal_pin_s;
      clk_src      <= decode_src(mode_s, crystal_pin_s); // RULE5 RULE6
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PLL_ENABLE       <= 1'b0;
      CLOCK_SOURCE     <= '0;
      OSC_INPUT_ENABLE <= 1'b1;
    end else begin
      PLL_ENABLE       <= mode_latched[1]; // RULE4
      CLOCK_SOURCE     <= clk_src;
      OSC_INPUT_ENABLE <= (clk_src != SRC_ONCHIP); // RULE7
    end
  end

  // While in reset the live mode decides whether the pin is being sampled
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CRYSTAL_PIN_OE  <= 1'b0;
      CRYSTAL_PIN_OUT <= 1'b0;
    end else begin
      CRYSTAL_PIN_OE  <= (phase == PH_HOLD) ? mode_s[0] : mode_latched[0]; // RULE8
      CRYSTAL_PIN_OUT <= !osc_s; // RULE8
    end
  end

  // ****************************************
  // Flash programming mode
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flash_mode <= 1'b0;
    end else if (leaving_hold) begin
      flash_mode <= !boot_n_s && !test_s; // RULE10
    end else if (wr_access && (PADDR == CTRL_OFFSET) && PWDATA[CTRL_FLASH_EXIT_BIT]) begin
      flash_mode <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FLASH_PROG_MODE   <= 1'b0;
      FLASH_PORT_ACCESS <= 1'b0;
    end else begin
      FLASH_PROG_MODE   <= flash_mode;
      FLASH_PORT_ACCESS <= flash_mode && (phase != PH_HOLD); // RULE11
    end
  end

  // ****************************************
  // Clock output
  // ****************************************
  // A flop cannot pass CLK itself, so the pin carries CLK divided by two
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SYSTEM_CLOCK_OUTPUT <= 1'b0;
    end else begin
      SYSTEM_CLOCK_OUTPUT <= system_clock_output_en && !SYSTEM_CLOCK_OUTPUT; // RULE9
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign setup     = PSEL && !PENABLE;
  assign wr_access = PSEL && PENABLE && PREADY && PWRITE;

  // One wait-free access phase: answer computed in setup, shown in access
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && (PADDR != CTRL_OFFSET) && (PADDR != STATUS_OFFSET);
      PRDATA  <= '0;
      if (setup && !PWRITE && (PADDR == CTRL_OFFSET)) begin
        PRDATA[CTRL_SYSTEM_CLOCK_OUTPUT_EN_BIT] <= system_clock_output_en;
      end else if (setup && !PWRITE && (PADDR == STATUS_OFFSET)) begin
        PRDATA[ST_MODE_LSB +: 2]    <= mode_latched;
        PRDATA[ST_CRYSTAL_PIN_BIT]         <= crystal_pin_latched;
        PRDATA[ST_PLL_BIT]          <= mode_latched[1];
        PRDATA[ST_SRC_LSB +: 2]     <= clk_src;
        PRDATA[ST_FLASH_BIT]        <= flash_mode;
        PRDATA[ST_CAUSE_PIN_BIT]    <= cause_pin;
        PRDATA[ST_CAUSE_SW_BIT]     <= cause_sw;
        PRDATA[ST_RESET_OUT_BIT]    <= (phase == PH_RUN);
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      system_clock_output_en <= CTRL_RESET_VALUE[CTRL_SYSTEM_CLOCK_OUTPUT_EN_BIT];
      sw_reset  <= 1'b0;
    end else begin
      sw_reset <= wr_access && (PADDR == CTRL_OFFSET) && PWDATA[CTRL_SW_RESET_BIT];
      if (wr_access && (PADDR == CTRL_OFFSET))
        system_clock_output_en <= PWDATA[CTRL_SYSTEM_CLOCK_OUTPUT_EN_BIT];
    end
  end

  // Cause of the latest reset; a new reset overwrites both bits
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cause_pin <= 1'b0;
      cause_sw  <= 1'b0;
    end else if ((phase != PH_HOLD) && source) begin
      cause_pin <= pin_reset;
      cause_sw  <= sw_reset;
    end
  end

endmodule : rcb_top

`default_nettype wire

// [logic/rcb_pkg.sv]
/*
  Constants shared by the reset and boot-configuration block: reset timing counts,
  the software register map and its field positions, and the clock-source type.
  Assumes one 250 MHz clock and 32-bit APB register access.
*/
`default_nettype none

package rcb_pkg;

  // ****************************************
  // Reset timing, in CPU clock cycles
  // ****************************************
  localparam int unsigned RESET_QUAL_CYCLES    = 8;
  localparam int unsigned RESET_STRETCH_CYCLES = 1024;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // Control fields
  localparam int unsigned CTRL_SW_RESET_BIT   = 0;
  localparam int unsigned CTRL_SYSTEM_CLOCK_OUTPUT_EN_BIT  = 1;
  localparam int unsigned CTRL_FLASH_EXIT_BIT = 2;
  localparam logic [31:0] CTRL_RESET_VALUE    = 32'h0000_0002;

  // Status fields
  localparam int unsigned ST_MODE_LSB       = 0;
  localparam int unsigned ST_CRYSTAL_PIN_BIT       = 2;
  localparam int unsigned ST_PLL_BIT        = 3;
  localparam int unsigned ST_SRC_LSB        = 4;
  localparam int unsigned ST_FLASH_BIT      = 6;
  localparam int unsigned ST_CAUSE_PIN_BIT  = 7;
  localparam int unsigned ST_CAUSE_SW_BIT   = 8;
  localparam int unsigned ST_RESET_OUT_BIT  = 9;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SRC_EXT_OSC,
    SRC_ONCHIP,
    SRC_CRYSTAL
  } rcb_clk_src_t;

  typedef enum logic [1:0] {
    PH_HOLD,
    PH_STRETCH,
    PH_RUN
  } rcb_phase_t;

endpackage : rcb_pkg

`default_nettype wire

// [logic/rcb_reset_filter.sv]
/*
  Reset pin qualifier: synchronises the active-low reset pin and reports a
  request only after the pin has been low for QUAL consecutive clock cycles.
  Assumes the pin is asynchronous to CLK.
*/
`default_nettype none

module rcb_reset_filter #(
  parameter int unsigned QUAL = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_n,
  output var  logic qualified
);

  logic                      sync1;
  logic                      sync2;
  logic [$clog2(QUAL+1)-1:0] low_count;

  // ****************************************
  // Synchroniser
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= pin_n;
      sync2 <= sync1;
    end
  end

  // ****************************************
  // Consecutive-low counter
  // ****************************************
  // Short glitches restart the count, so noise never resets the chip
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_count <= '0;
      qualified <= 1'b0;
    end else if (sync2) begin
      low_count <= '0;
      qualified <= 1'b0;
    end else if (low_count == ($clog2(QUAL+1))'(QUAL - 1)) begin
      qualified <= 1'b1; // RULE1
    end else begin
      low_count <= low_count + 1'b1;
    end
  end

endmodule : rcb_reset_filter

`default_nettype wire

// [tb/rcb_props.sv]
/*
  Port checker for rcb_top: reset stretch, boot clock decode and pin control.
  Bound to every rcb_top; assumes the boot pins stay stable across a reset.
*/
`default_nettype none

module rcb_props
  import rcb_pkg::*;
#(
  parameter int unsigned QUAL_CYCLES    = 8,
  parameter int unsigned STRETCH_CYCLES = 1024
) (
  // Clock, reset and board pins
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       RESET_IN_N,
  input wire logic [1:0] CLOCK_MODE_SELECT,
  input wire logic       CRYSTAL_PIN_IN,
  // Outputs under check
  input wire logic       CRYSTAL_PIN_OE,
  input wire logic       RESET_OUT_N,
  input wire logic       SYSTEM_CLOCK_OUTPUT,
  input wire logic       CHIP_RESET,
  input wire logic       PLL_ENABLE,
  input wire logic [1:0] CLOCK_SOURCE,
  input wire logic       OSC_INPUT_ENABLE,
  input wire logic       FLASH_PROG_MODE,
  input wire logic       FLASH_PORT_ACCESS
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  mode_l;
  logic        crystal_pin_l;
  logic [15:0] run_cnt;
  logic [7:0]  low_cnt;

  // Straps frozen when the chip leaves reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_l <= 2'h0;
      crystal_pin_l <= 1'b0;
    end else if (CHIP_RESET) begin
      mode_l <= CLOCK_MODE_SELECT;
      crystal_pin_l <= CRYSTAL_PIN_IN;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      run_cnt <= 16'h0;
    else
      run_cnt <= (CHIP_RESET || RESET_OUT_N) ? 16'h0 : run_cnt + 16'h1;
  end

  // Saturates so a long hold never wraps back below the threshold
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      low_cnt <= 8'h0;
    else
      low_cnt <= RESET_IN_N ? 8'h0 : low_cnt + {7'h0, low_cnt != 8'hff};
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence rel_s;
    $fell(CHIP_RESET);
  endsequence

  rst_out_low_a: assert property (CHIP_RESET |-> !RESET_OUT_N)
    else $error("reset out released during chip reset");
  stretch_min_a: assert property (rel_s |-> !RESET_OUT_N [*8])
    else $error("reset out released too early");
  stretch_len_a: assert property ($rose(RESET_OUT_N) |-> run_cnt == STRETCH_CYCLES)
    else $error("reset stretch length wrong");
  qual_len_a: assert property ($rose(CHIP_RESET) && !RESET_IN_N |-> low_cnt >= QUAL_CYCLES)
    else $error("reset taken from a short pulse");
  pll_mode_a: assert property (RESET_OUT_N |-> PLL_ENABLE == mode_l[1])
    else $error("pll enable wrong");
  crystal_pin_src_a: assert property (RESET_OUT_N && mode_l[0] |-> CLOCK_SOURCE == SRC_CRYSTAL)
    else $error("crystal source not chosen");
  pin_src_a: assert property (RESET_OUT_N && !mode_l[0]
    |-> CLOCK_SOURCE == (crystal_pin_l ? SRC_ONCHIP : SRC_EXT_OSC))
    else $error("sampled source wrong");
  osc_in_a: assert property (RESET_OUT_N
    |-> OSC_INPUT_ENABLE == (CLOCK_SOURCE != SRC_ONCHIP))
    else $error("oscillator input enable wrong");
  crystal_pin_oe_a: assert property (RESET_OUT_N |-> CRYSTAL_PIN_OE == mode_l[0])
    else $error("crystal pin drive wrong");
  clk_out_a: assert property (SYSTEM_CLOCK_OUTPUT |=> !SYSTEM_CLOCK_OUTPUT)
    else $error("clock output stuck high");
  flash_port_a: assert property (FLASH_PORT_ACCESS |-> FLASH_PROG_MODE)
    else $error("flash port open outside programming");
endmodule : rcb_props

bind rcb_top rcb_props #(
  .QUAL_CYCLES   (QUAL_CYCLES),
  .STRETCH_CYCLES(STRETCH_CYCLES)
) u_props (
  .CLK(CLK), .RST(RST), .RESET_IN_N(RESET_IN_N), .CLOCK_MODE_SELECT(CLOCK_MODE_SELECT),
  .CRYSTAL_PIN_IN(CRYSTAL_PIN_IN), .CRYSTAL_PIN_OE(CRYSTAL_PIN_OE),
  .RESET_OUT_N(RESET_OUT_N), .SYSTEM_CLOCK_OUTPUT(SYSTEM_CLOCK_OUTPUT),
  .CHIP_RESET(CHIP_RESET), .PLL_ENABLE(PLL_ENABLE), .CLOCK_SOURCE(CLOCK_SOURCE),
  .OSC_INPUT_ENABLE(OSC_INPUT_ENABLE), .FLASH_PROG_MODE(FLASH_PROG_MODE),
  .FLASH_PORT_ACCESS(FLASH_PORT_ACCESS)
);

`default_nettype wire

// [tb/rcb_board.sv]
/*
  Board model: reset source, boot straps, free-running oscillator, crystal pin.
  Assumes the bench sets the strap and reset levels.
*/
`default_nettype none

module rcb_board (
  // Levels from the bench
  input  wire logic       rin_n,
  input  wire logic [1:0] mode,
  input  wire logic       boot_n,
  input  wire logic       crystal_pin,
  input  wire logic       test,
  // Crystal pin drive from the device
  input  wire logic       xo,
  input  wire logic       xoe,
  // Board pins
  output wire logic       reset_in_n,
  output wire logic [1:0] clock_mode_select,
  output wire logic       boot_config_n,
  output wire logic       test_pin,
  output var  logic       osc_clock_input,
  output wire logic       crystal_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial osc_clock_input = 1'b0;
  // Oscillator runs free and unrelated to the core clock
  always #3 osc_clock_input = ~osc_clock_input;
  assign reset_in_n        = rin_n;
  assign clock_mode_select = mode;
  assign boot_config_n     = boot_n;
  assign test_pin          = test;
  // Strap resistor only wins while the device does not drive the pin
  assign crystal_pin_in    = xoe ? xo : crystal_pin;
endmodule : rcb_board

`default_nettype wire

// [tb/tb.sv]
/*
  Bench for rcb_top: APB tasks, boot mode sweep, reset pulses, flash entry.
  Assumes rcb_board drives the pins and rcb_props is bound.
*/
`default_nettype none

module tb;
  import rcb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        rin_n = 1, boot_n = 1, crystal_pin = 0, test = 0, e, s;
  logic [1:0]  mode = 0, cms, clock_source;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  wire logic   pready, pslverr, reset_in_n, boot_config_n, test_pin, osc_clock_input;
  wire logic   crystal_pin_in, crystal_pin_out, crystal_pin_oe, reset_out_n, sysclk;
  wire logic   chip_reset, pll_enable, osc_input_enable, flash_prog_mode, flash_port_access;
  rcb_clk_src_t src;
  int          num_errors = 0, n_checks = 0, cyc = 0, t;

  rcb_top #(.STRETCH_CYCLES(16)) uut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RESET_IN_N(reset_in_n), .CLOCK_MODE_SELECT(cms), .BOOT_CONFIG_N(boot_config_n),
    .TEST_PIN(test_pin), .OSC_CLOCK_INPUT(osc_clock_input), .CRYSTAL_PIN_IN(crystal_pin_in),
    .CRYSTAL_PIN_OUT(crystal_pin_out), .CRYSTAL_PIN_OE(crystal_pin_oe),
    .RESET_OUT_N(reset_out_n), .SYSTEM_CLOCK_OUTPUT(sysclk), .CHIP_RESET(chip_reset),
    .PLL_ENABLE(pll_enable), .CLOCK_SOURCE(clock_source), .OSC_INPUT_ENABLE(osc_input_enable),
    .FLASH_PROG_MODE(flash_prog_mode), .FLASH_PORT_ACCESS(flash_port_access)
  );
  rcb_board board (
    .rin_n(rin_n), .mode(mode), .boot_n(boot_n), .crystal_pin(crystal_pin), .test(test),
    .xo(crystal_pin_out),
    .xoe(crystal_pin_oe), .reset_in_n(reset_in_n), .clock_mode_select(cms),
    .boot_config_n(boot_config_n), .test_pin(test_pin),
    .osc_clock_input(osc_clock_input), .crystal_pin_in(crystal_pin_in)
  );

  always #2 clk = ~clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    t = 0;
    do @(posedge clk); while (pready !== 1 && ++t < 50);
    if (pready !== 1)
      num_errors++;
    r = prdata;
    e = pslverr;
    psel    <= 0;
    penable <= 0;
    // One idle edge so a following call never re-raises psel in this step
    @(posedge clk);
  endtask : apb

  task automatic pin_rst(input int n);
    rin_n <= 0;
    repeat (n) @(posedge clk);
    rin_n <= 1;
  endtask : pin_rst

  // Waits for the chip reset to start, then for the reset output release
  task automatic boot;
    t = 0;
    while (chip_reset !== 1 && t < 40) begin
      @(posedge clk);
      t++;
    end
    while (reset_out_n !== 1 && t < 200) begin
      @(posedge clk);
      t++;
    end
    chk(reset_out_n, 1);
    chk(chip_reset, 0);
  endtask : boot

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 8; i++) begin
      mode <= i[2:1];
      crystal_pin <= i[0];
      src = i[1] ? SRC_CRYSTAL : (i[0] ? SRC_ONCHIP : SRC_EXT_OSC);
      pin_rst(20);
      boot();
      chk(pll_enable, i[2]);
      chk(clock_source, src);
      chk(osc_input_enable, !(i[0] && !i[1]));
      chk(crystal_pin_oe, i[1]);
      apb(0, STATUS_OFFSET, 0);
      chk(r & 32'h3b, {26'h0, src, i[2], 1'b0, i[2:1]});
    end
    pin_rst(7);
    repeat (20) begin
      @(posedge clk);
      chk(chip_reset, 0);
    end
    pin_rst(8);
    boot();
    apb(0, STATUS_OFFSET, 0);
    chk(r[9:7], 3'b101);
    apb(0, CTRL_OFFSET, 0);
    chk(r, CTRL_RESET_VALUE);
    apb(0, 12'h008, 0);
    chk(e, 1);
    chk(r, 0);
    apb(1, CTRL_OFFSET, 32'h3);
    boot();
    apb(0, STATUS_OFFSET, 0);
    chk(r[9:7], 3'b110);
    apb(1, CTRL_OFFSET, 32'h2);
    s = sysclk;
    @(posedge clk);
    chk(sysclk, !s);
    apb(1, CTRL_OFFSET, 32'h0);
    repeat (3) @(posedge clk);
    chk(sysclk, 0);
    boot_n <= 0;
    test   <= 1;
    pin_rst(20);
    boot();
    chk(flash_prog_mode, 0);
    test   <= 0;
    pin_rst(20);
    boot();
    chk(flash_prog_mode, 1);
    chk(flash_port_access, 1);
    apb(1, CTRL_OFFSET, 32'h6);
    repeat (2) @(posedge clk);
    chk(flash_port_access, 0);
    chk(flash_prog_mode, 0);
    s = crystal_pin_out;
    e = 0;
    repeat (6) begin
      @(posedge clk);
      e |= (crystal_pin_out !== s);
    end
    chk(e, 1);
    give_verdict();
  end
endmodule : tb

`default_nettype wire
